/* File: hw/sms_string_move_sequencer.sv */
// string move sequencer: wishbone slave, register file, load/store engine
`timescale 1ns/10ps
`default_nettype none
module sms_string_move_sequencer
  import sms_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             mem_rd_req_o,
  output logic      [31:0] mem_rd_addr_o,
  input  wire logic        mem_rd_ack_i,
  input  wire logic [7:0]  mem_rd_data_i,
  output logic             mem_wr_valid_o,
  output logic      [31:0] mem_wr_addr_o,
  output logic      [7:0]  mem_wr_data_o,
  input  wire logic        mem_wr_ready_i,
  output logic             busy_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] gpr [SMS_NUM_GPR];
  logic [31:0] fxstat;
  logic [31:0] ea;
  logic        done;
  sms_state_e  state;
  sms_op_e     op;
  logic [7:0]  total;
  logic [7:0]  cnt;
  logic [4:0]  reg_idx;
  logic [1:0]  lane;
  logic [31:0] acc;

  sms_strm_if #(.WIDTH(40)) wr_in ();
  sms_strm_if #(.WIDTH(40)) wr_out ();

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic        bus_req;
  logic        bus_wr;
  logic        is_gpr;
  logic [4:0]  gpr_sel;
  logic [31:0] bus_mask;
  logic [31:0] rd_mux;

  assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr   = bus_req & wb_we_i;
  assign is_gpr   = (wb_adr_i[7] == SMS_GPR_SEL);
  assign gpr_sel  = wb_adr_i[6:2];
  assign bus_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (is_gpr) begin
      rd_mux = gpr[gpr_sel];
    end else begin
      case ({wb_adr_i[7:2], 2'b00})
        SMS_OFF_FXSTAT: rd_mux = fxstat;
        SMS_OFF_STATUS: rd_mux = {30'h0, done, (state != SMS_IDLE)};
        SMS_OFF_EA:     rd_mux = ea;
        default:        rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= (bus_req & ~wb_we_i) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fxstat <= SMS_FXSTAT_RST;
    end else if (bus_wr && !is_gpr && {wb_adr_i[7:2], 2'b00} == SMS_OFF_FXSTAT) begin
      fxstat <= (fxstat & ~bus_mask) | (wb_dat_i & bus_mask);
    end
  end

  // ----------------------------------------------------------------
  // command accept
  // ----------------------------------------------------------------
  logic        cmd_go;
  sms_op_e     cmd_op;
  logic [4:0]  cmd_first;
  logic [4:0]  cmd_base;
  logic [4:0]  cmd_index;
  logic [4:0]  cmd_imm;
  logic        cmd_indexed;
  logic [31:0] base_val;
  logic [31:0] cmd_ea;
  logic [7:0]  cmd_total;

  assign cmd_go    = bus_wr && !is_gpr && {wb_adr_i[7:2], 2'b00} == SMS_OFF_CMD
                     && state == SMS_IDLE;
  assign cmd_op    = sms_op_e'(wb_dat_i[SMS_CMD_OP_LSB +: 2]);
  assign cmd_first = wb_dat_i[SMS_CMD_FIRST_LSB +: 5];
  assign cmd_base  = wb_dat_i[SMS_CMD_BASE_LSB +: 5];
  assign cmd_index = wb_dat_i[SMS_CMD_INDEX_LSB +: 5];
  assign cmd_imm   = wb_dat_i[SMS_CMD_IMM_LSB +: 5];
  assign cmd_indexed = (cmd_op == SMS_OP_LOAD_IDX) || (cmd_op == SMS_OP_STORE_IDX);
  assign base_val  = (cmd_base == 5'h00) ? 32'h0000_0000 : gpr[cmd_base];

  always_comb begin
    if (cmd_indexed) begin
      cmd_ea    = base_val + gpr[cmd_index];
      cmd_total = {1'b0, fxstat[SMS_FX_CNT_LSB +: SMS_FX_CNT_W]};
    end else begin
      cmd_ea    = base_val;
      cmd_total = (cmd_imm == 5'h00) ? SMS_IMM_ZERO_BYTES : {3'h0, cmd_imm};
    end
  end

  // ----------------------------------------------------------------
  // load datapath
  // ----------------------------------------------------------------
  logic        ld_take;
  logic        ld_last;
  logic [31:0] next_acc;
  logic [31:0] cur_addr;

  assign cur_addr = ea + {24'h00_0000, cnt};
  assign ld_take  = (state == SMS_LOAD) & mem_rd_req_o & mem_rd_ack_i;
  assign ld_last  = (cnt + 8'h01) == total;

  always_comb begin
    if (lane == 2'h0) begin
      next_acc = {mem_rd_data_i, 24'h00_0000};
    end else begin
      next_acc = acc | ({24'h00_0000, mem_rd_data_i} << (5'd24 - {lane, 3'b000}));
    end
  end

  // ----------------------------------------------------------------
  // store datapath
  // ----------------------------------------------------------------
  logic [7:0] st_byte;
  logic       st_push;
  logic       st_last;

  assign st_byte  = gpr[reg_idx][5'd31 - {lane, 3'b000} -: 8];
  assign st_push  = (state == SMS_STORE) & wr_in.ready;
  assign st_last  = (cnt + 8'h01) == total;
  assign wr_in.valid = (state == SMS_STORE);
  assign wr_in.data  = {cur_addr, st_byte};

  sms_buf2 #(.WIDTH(40)) u_wr_buf (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .in_if  (wr_in),
    .out_if (wr_out)
  );

  assign wr_out.ready   = mem_wr_ready_i;
  assign mem_wr_valid_o = wr_out.valid;
  assign mem_wr_addr_o  = wr_out.data[39:8];
  assign mem_wr_data_o  = wr_out.data[7:0];

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state   <= SMS_IDLE;
      op      <= SMS_OP_LOAD_IMM;
      total   <= 8'h00;
      cnt     <= 8'h00;
      reg_idx <= 5'h00;
      lane    <= 2'h0;
      ea      <= 32'h0000_0000;
      done    <= 1'b0;
    end else begin
      case (state)
        SMS_IDLE: begin
          if (cmd_go) begin
            op      <= cmd_op;
            total   <= cmd_total;
            cnt     <= 8'h00;
            reg_idx <= cmd_first;
            lane    <= 2'h0;
            ea      <= cmd_ea;
            done    <= 1'b0;
            if (cmd_total == 8'h00) begin
              done <= 1'b1;
            end else if (cmd_op == SMS_OP_LOAD_IMM || cmd_op == SMS_OP_LOAD_IDX) begin
              state <= SMS_LOAD;
            end else begin
              state <= SMS_STORE;
            end
          end
        end
        SMS_LOAD: begin
          if (ld_take) begin
            cnt  <= cnt + 8'h01;
            lane <= lane + 2'h1;
            if (lane == SMS_LAST_LANE) begin
              reg_idx <= reg_idx + 5'h01;
            end
            if (ld_last) begin
              state <= SMS_IDLE;
              done  <= 1'b1;
            end
          end
        end
        SMS_STORE: begin
          if (st_push) begin
            cnt  <= cnt + 8'h01;
            lane <= lane + 2'h1;
            if (lane == SMS_LAST_LANE) begin
              reg_idx <= reg_idx + 5'h01;
            end
            if (st_last) begin
              state <= SMS_DRAIN;
            end
          end
        end
        SMS_DRAIN: begin
          if (wr_in.ready && !wr_out.valid) begin
            state <= SMS_IDLE;
            done  <= 1'b1;
          end
        end
        default: state <= SMS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_rd_req_o  <= 1'b0;
      mem_rd_addr_o <= 32'h0000_0000;
    end else if (mem_rd_req_o) begin
      if (mem_rd_ack_i) begin
        mem_rd_req_o <= 1'b0;
      end
    end else if (state == SMS_LOAD) begin
      mem_rd_req_o  <= 1'b1;
      mem_rd_addr_o <= cur_addr;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc <= 32'h0000_0000;
    end else if (ld_take) begin
      acc <= next_acc;
    end
  end

  // sequencer write wins over a bus write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < SMS_NUM_GPR; i++) begin
        gpr[i] <= SMS_GPR_RST;
      end
    end else if (ld_take && (lane == SMS_LAST_LANE || ld_last)) begin
      gpr[reg_idx] <= next_acc;
    end else if (bus_wr && is_gpr) begin
      gpr[gpr_sel] <= (gpr[gpr_sel] & ~bus_mask) | (wb_dat_i & bus_mask);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (state != SMS_IDLE) | cmd_go;
    end
  end

endmodule
`default_nettype wire

/* File: hw/sms_pkg.sv */
// constants, field layouts and types of the string move sequencer
package sms_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] SMS_OFF_CMD    = 8'h00;
  localparam logic [7:0] SMS_OFF_FXSTAT = 8'h04;
  localparam logic [7:0] SMS_OFF_STATUS = 8'h08;
  localparam logic [7:0] SMS_OFF_EA     = 8'h0C;
  localparam logic [7:0] SMS_OFF_GPR    = 8'h80;
  localparam logic [0:0] SMS_GPR_SEL    = 1'h1;

  // ----------------------------------------------------------------
  // command word fields
  // ----------------------------------------------------------------
  localparam int SMS_CMD_OP_LSB    = 0;
  localparam int SMS_CMD_FIRST_LSB = 2;
  localparam int SMS_CMD_BASE_LSB  = 7;
  localparam int SMS_CMD_INDEX_LSB = 12;
  localparam int SMS_CMD_IMM_LSB   = 17;

  // ----------------------------------------------------------------
  // status word fields, reset values
  // ----------------------------------------------------------------
  localparam int SMS_ST_BUSY = 0;
  localparam int SMS_ST_DONE = 1;
  localparam logic [31:0] SMS_FXSTAT_RST = 32'h0000_0000;
  localparam logic [31:0] SMS_GPR_RST    = 32'h0000_0000;

  // byte count bits 25..31 of the fxstat word, msb-0 numbering
  localparam int SMS_FX_CNT_LSB   = 0;
  localparam int SMS_FX_CNT_W     = 7;

  // ----------------------------------------------------------------
  // counts
  // ----------------------------------------------------------------
  localparam logic [7:0] SMS_IMM_ZERO_BYTES = 8'h20;
  localparam logic [1:0] SMS_LAST_LANE      = 2'h3;
  localparam int         SMS_NUM_GPR        = 32;

  typedef enum logic [1:0] {
    SMS_OP_LOAD_IMM   = 2'b00,
    SMS_OP_LOAD_IDX   = 2'b01,
    SMS_OP_STORE_IMM  = 2'b10,
    SMS_OP_STORE_IDX  = 2'b11
  } sms_op_e;

  typedef enum logic [1:0] {
    SMS_IDLE  = 2'b00,
    SMS_LOAD  = 2'b01,
    SMS_STORE = 2'b10,
    SMS_DRAIN = 2'b11
  } sms_state_e;

endpackage

/* File: hw/sms_strm_if.sv */
// valid/ready stream carrier between sequencer and buffer
`timescale 1ns/10ps
`default_nettype none
interface sms_strm_if #(
  parameter int WIDTH = 40
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: hw/sms_buf2.sv */
// two-entry registered buffer with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module sms_buf2 #(
  parameter int WIDTH = 40
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  sms_strm_if.snk   in_if,
  sms_strm_if.src   out_if
);

  logic [WIDTH-1:0] head;
  logic [WIDTH-1:0] tail;
  logic             head_vld;
  logic             tail_vld;
  logic             push;
  logic             pop;

  if (WIDTH < 1) begin : g_chk
    $error("sms_buf2: WIDTH must be at least 1");
  end

  assign in_if.ready  = ~tail_vld;
  assign out_if.valid = head_vld;
  assign out_if.data  = head;
  assign push         = in_if.valid & ~tail_vld;
  assign pop          = head_vld & out_if.ready;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      head_vld <= 1'b0;
      tail_vld <= 1'b0;
      head     <= '0;
      tail     <= '0;
    end else if (pop) begin
      if (tail_vld) begin
        head     <= tail;
        tail_vld <= 1'b0;
      end else if (push) begin
        head <= in_if.data;
      end else begin
        head_vld <= 1'b0;
      end
    end else if (push) begin
      if (!head_vld) begin
        head     <= in_if.data;
        head_vld <= 1'b1;
      end else begin
        tail     <= in_if.data;
        tail_vld <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* File: testbench/sms_string_move_sequencer_asserts.sv */
// port checker for the string move sequencer, bound to its top module
`timescale 1ns/10ps
`default_nettype none
module sms_seq_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        mem_rd_req_o,
  input wire logic [31:0] mem_rd_addr_o,
  input wire logic        mem_rd_ack_i,
  input wire logic        mem_wr_valid_o,
  input wire logic [31:0] mem_wr_addr_o,
  input wire logic [7:0]  mem_wr_data_o,
  input wire logic        mem_wr_ready_i,
  input wire logic        busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // last accepted byte address of each port within one run
  // ----------------------------------------------------------------
  logic [31:0] last_rd;
  logic [31:0] last_wr;
  logic        seen_rd;
  logic        seen_wr;
  always_ff @(posedge clk_i) begin
    seen_rd <= !rst_i && busy_o && (seen_rd || (mem_rd_req_o && mem_rd_ack_i));
    seen_wr <= !rst_i && busy_o && (seen_wr || (mem_wr_valid_o && mem_wr_ready_i));
    if (mem_rd_req_o && mem_rd_ack_i) last_rd <= mem_rd_addr_o;
    if (mem_wr_valid_o && mem_wr_ready_i) last_wr <= mem_wr_addr_o;
  end
  property p_wb_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bus request not acked");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_rd_hold;
    mem_rd_req_o && !mem_rd_ack_i |=> mem_rd_req_o && $stable(mem_rd_addr_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read request not held");
  property p_rd_gap; mem_rd_req_o && mem_rd_ack_i |=> !mem_rd_req_o; endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("read request without gap");
  property p_rd_asc; mem_rd_req_o && seen_rd |-> mem_rd_addr_o == last_rd + 32'h1; endproperty
  a_rd_asc: assert property (p_rd_asc) else $error("read address skipped");
  property p_wr_hold;
    mem_wr_valid_o && !mem_wr_ready_i |=> mem_wr_valid_o && $stable(mem_wr_addr_o)
      && $stable(mem_wr_data_o);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write beat not held");
  property p_wr_asc; mem_wr_valid_o && seen_wr |-> mem_wr_addr_o == last_wr + 32'h1; endproperty
  a_wr_asc: assert property (p_wr_asc) else $error("write address skipped");
  property p_idle; !busy_o |-> !mem_rd_req_o && !mem_wr_valid_o; endproperty
  a_idle: assert property (p_idle) else $error("memory access while idle");
  c_rd: cover property (mem_rd_req_o && mem_rd_ack_i);
  c_stall: cover property (mem_wr_valid_o && !mem_wr_ready_i);
  c_end: cover property ($fell(busy_o));
endmodule
bind sms_string_move_sequencer sms_seq_asserts i_sms_seq_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_rd_req_o(mem_rd_req_o),
  .mem_rd_addr_o(mem_rd_addr_o), .mem_rd_ack_i(mem_rd_ack_i),
  .mem_wr_valid_o(mem_wr_valid_o), .mem_wr_addr_o(mem_wr_addr_o),
  .mem_wr_data_o(mem_wr_data_o), .mem_wr_ready_i(mem_wr_ready_i), .busy_o(busy_o));
`default_nettype wire

/* File: testbench/sms_mem_model.sv */
// data memory port model: reads after 0..3 waits, writes stall in bursts
`timescale 1ns/10ps
`default_nettype none
module sms_mem_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        rd_req_i,
  input  wire logic [31:0] rd_addr_i,
  output logic             rd_ack_o,
  output logic      [7:0]  rd_data_o,
  output logic             wr_ready_o
);
  logic [15:0] lfsr;
  logic [3:0]  phase;
  logic [1:0]  wait_cnt;
  always_ff @(posedge clk_i) begin
    lfsr <= rst_i ? 16'hACE1 : {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    phase <= rst_i ? 4'h0 : phase + 4'h1;
    // at least eight stalled cycles of every sixteen fill the buffer
    wr_ready_o <= !rst_i && phase[3] && lfsr[0];
    rd_ack_o <= !rst_i && rd_req_i && !rd_ack_o && wait_cnt == 2'h0;
    if (!rd_req_i || rd_ack_o) wait_cnt <= lfsr[2:1];
    else if (wait_cnt != 2'h0) wait_cnt <= wait_cnt - 2'h1;
    // data folds every address bit, only valid with ack, inverted otherwise
    if (rst_i) rd_data_o <= 8'h00;
    else if (rd_req_i && !rd_ack_o && wait_cnt == 2'h0)
      rd_data_o <= rd_addr_i[7:0] ^ rd_addr_i[15:8] ^ rd_addr_i[23:16] ^ rd_addr_i[31:24] ^ 8'hC3;
    else rd_data_o <= ~rd_data_o;
  end
endmodule
`default_nettype wire

/* File: testbench/sms_string_move_sequencer_tb_top.sv */
// self-checking bench for the string move sequencer
`timescale 1ns/10ps
`default_nettype none
module sms_string_move_sequencer_tb_top
  import sms_pkg::*;
;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, busy_o;
  logic        mem_rd_req_o, mem_rd_ack_i, mem_wr_valid_o, mem_wr_ready_i;
  logic [7:0]  wb_adr_i, mem_rd_data_i, mem_wr_data_o;
  logic [31:0] wb_dat_i, wb_dat_o, mem_rd_addr_o, mem_wr_addr_o, ea;
  logic [31:0] seed = 32'h5;
  logic [31:0] gpr [32];
  logic [39:0] rd_q [$];
  logic [39:0] wr_q [$];
  logic [6:0]  fx;
  logic [3:0]  wb_sel_i, sel_mask;
  int          bad_count, samples_checked;
  sms_string_move_sequencer i_sms_string_move_sequencer (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_rd_req_o(mem_rd_req_o),
    .mem_rd_addr_o(mem_rd_addr_o), .mem_rd_ack_i(mem_rd_ack_i),
    .mem_rd_data_i(mem_rd_data_i), .mem_wr_valid_o(mem_wr_valid_o),
    .mem_wr_addr_o(mem_wr_addr_o), .mem_wr_data_o(mem_wr_data_o),
    .mem_wr_ready_i(mem_wr_ready_i), .busy_o(busy_o));
  sms_mem_model i_sms_mem_model (
    .clk_i(clk_i), .rst_i(rst_i), .rd_req_i(mem_rd_req_o), .rd_addr_i(mem_rd_addr_o),
    .rd_ack_o(mem_rd_ack_i), .rd_data_o(mem_rd_data_i), .wr_ready_o(mem_wr_ready_i));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] %0t %s", $time, m);
      bad_count++;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_sel_i <= sel_mask;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) @(posedge clk_i);
    chk(40'(wb_ack_o), 40'h1, "bus timeout");
    if (wb_ack_o !== 1'b1) give_verdict();
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back({8'h0, e});
    wb(1'b0, a, 32'h0);
  endtask
  // results leave through the outputs, oldest expectation first
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && !wb_we_i) chk({8'h0, wb_dat_o}, rd_q.pop_front(), "read");
    if (mem_wr_valid_o === 1'b1 && mem_wr_ready_i)
      chk({mem_wr_addr_o, mem_wr_data_o}, wr_q.pop_front(), "mem write");
  end
  task automatic go(input logic [1:0] op, input logic [4:0] f, b, x, n);
    int k, cnt;
    logic [31:0] a;
    logic [4:0]  r;
    cnt = op[0] ? int'(fx) : (n == 5'h0 ? 32 : int'(n));
    ea = (b == 5'h0 ? 32'h0 : gpr[b]) + (op[0] ? gpr[x] : 32'h0);
    for (k = 0; k < cnt; k++) begin
      a = ea + 32'(k);
      r = f + 5'(k / 4);
      if (op[1]) wr_q.push_back({a, gpr[r][31 - 8 * (k % 4) -: 8]});
      else begin
        if (k % 4 == 0) gpr[r] = 32'h0;
        gpr[r][31 - 8 * (k % 4) -: 8] = a[7:0] ^ a[15:8] ^ a[23:16] ^ a[31:24] ^ 8'hC3;
      end
    end
    wb(1'b1, SMS_OFF_CMD, {10'h0, n, x, b, f, op});
    // a second command while busy must be ignored
    if (cnt > 4) wb(1'b1, SMS_OFF_CMD, {10'h0, 5'd1, 5'd0, 5'd0, f, 2'h0});
    for (k = 0; k < 4000 && busy_o !== 1'b0; k++) @(posedge clk_i);
    chk(40'(busy_o), 40'h0, "command hang");
    if (busy_o !== 1'b0) give_verdict();
    chk(40'(wr_q.size()), 40'h0, "bytes missing");
    rd(SMS_OFF_EA, ea);
    rd(SMS_OFF_STATUS, 32'h2);
    for (k = 0; k < 32; k++) rd(SMS_OFF_GPR + 8'(4 * k), gpr[k]);
    $display("test op %0d first %0d count %0d done", op, f, cnt);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    int i;
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} <= 4'h8;
    wb_adr_i <= 8'h00;
    wb_dat_i <= 32'h0;
    wb_sel_i <= 4'hF;
    sel_mask = 4'hF;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(SMS_OFF_FXSTAT, SMS_FXSTAT_RST);
    rd(SMS_OFF_GPR, SMS_GPR_RST);
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0);
    // byte enables pick the written lanes
    sel_mask = 4'h5;
    wb(1'b1, SMS_OFF_FXSTAT, 32'hFFFF_FFFF);
    sel_mask = 4'hF;
    rd(SMS_OFF_FXSTAT, 32'h00FF_00FF);
    $display("test register access done");
    for (i = 0; i < 32; i++) begin
      gpr[i] = xs();
      wb(1'b1, SMS_OFF_GPR + 8'(4 * i), gpr[i]);
    end
    fx = 7'h00;
    wb(1'b1, SMS_OFF_FXSTAT, 32'h0);
    go(2'h2, 5'd30, 5'd5, 5'd0, 5'd11);
    go(2'h2, 5'd31, 5'd0, 5'd0, 5'd0);
    go(2'h3, 5'd4, 5'd2, 5'd3, 5'd0);
    go(2'h0, 5'd30, 5'd31, 5'd0, 5'd9);
    go(2'h1, 5'd12, 5'd1, 5'd2, 5'd0);
    fx = 7'h0D;
    wb(1'b1, SMS_OFF_FXSTAT, 32'h0000_000D);
    go(2'h3, 5'd29, 5'd3, 5'd4, 5'd0);
    go(2'h1, 5'd7, 5'd0, 5'd9, 5'd0);
    give_verdict();
  end
endmodule
`default_nettype wire
